// >>> hdl/bsx_exec.sv
// Decode and execute for set-bit, skip-if-clear, speed and three subtracts.
// Assumes program memory holds insn valid and data memory answers reads combinationally.
`timescale 1ns/1ns
module bsx_exec #(
    parameter int DIV_W = bsx_pkg::DIV_W
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [15:0] insn,
    output logic insn_fetch,
    input wire logic [7:0] mem_rdata,
    output logic [8:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    input wire logic [7:0] acc_in,
    output logic [7:0] acc_wdata,
    output logic acc_we,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic [7:0] clock_speed_control,
    output logic [1:0] power_down_select,
    output logic [1:0] clock_source_select,
    output logic [DIV_W-1:0] core_clock_divisor,
    output logic skip_active
);
    logic rst_sync1_reg;
    logic rst_n;
    logic tick;
    logic squash_reg;
    logic [7:0] speed_reg;
    logic carry_reg;
    logic dc_reg;
    logic zero_reg;

    // Reset release through two flip-flops.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n <= rst_sync1_reg;
        end
    end

    // Instruction cycle enable from the divisor in force.
    bsx_divider #(.DIV_W(DIV_W)) u_div (
        .clock(clock),
        .rst_n(rst_n),
        .divisor(speed_reg[DIV_W-1:0]),
        .tick(tick)
    );

    // Opcode decode.
    logic is_setb, is_snb, is_speed, is_sub_fr, is_sub_w, is_sub_lit, is_sub;
    logic live;
    logic [2:0] bit_sel;
    logic [7:0] immediate_byte;
    logic [7:0] memory_operand;
    logic [7:0] minuend;
    logic [7:0] bit_mask;
    // Nothing executes or fetches until the synchronised reset has let go, so program
    // memory stays on its first word and no strobe reaches memory during reset.
    assign live = tick && !squash_reg && rst_n;
    assign is_setb = (insn & bsx_pkg::MASK_BIT) == bsx_pkg::OP_SETB;
    assign is_snb = (insn & bsx_pkg::MASK_BIT) == bsx_pkg::OP_SNB;
    assign is_speed = (insn & bsx_pkg::MASK_LIT) == bsx_pkg::OP_SPEED;
    assign is_sub_fr = (insn & bsx_pkg::MASK_FR) == bsx_pkg::OP_SUB_FR;
    assign is_sub_w = (insn & bsx_pkg::MASK_FR) == bsx_pkg::OP_SUB_W;
    assign is_sub_lit = (insn & bsx_pkg::MASK_LIT) == bsx_pkg::OP_SUB_LIT;
    assign is_sub = is_sub_fr || is_sub_w || is_sub_lit;
    assign bit_sel = insn[bsx_pkg::BIT_LSB +: bsx_pkg::BIT_W];
    assign immediate_byte = insn[bsx_pkg::LIT_W-1:0];
    assign mem_addr = insn[bsx_pkg::ADDR_W-1:0];
    assign memory_operand = mem_rdata;
    assign bit_mask = 8'h01 << bit_sel;

    // Subtraction with borrow detection; each form ends in one cycle.
    logic [8:0] diff;
    logic [4:0] low_diff;
    assign minuend = is_sub_lit ? immediate_byte : memory_operand;
    assign diff = {1'b0, minuend} - {1'b0, acc_in};
    assign low_diff = {1'b0, minuend[3:0]} - {1'b0, acc_in[3:0]};

    // Write strobes and data for memory and accumulator.
    logic bit_clear;
    assign bit_clear = (memory_operand & bit_mask) == 8'h00;
    assign mem_we = live && (is_setb || is_sub_fr);
    assign mem_wdata = is_setb ? (memory_operand | bit_mask) : diff[7:0];
    assign acc_we = live && (is_sub_w || is_sub_lit);
    assign acc_wdata = diff[7:0];
    assign insn_fetch = tick && rst_n;
    assign skip_active = squash_reg;

    // Skip state: the next instruction cycle is squashed.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            squash_reg <= 1'b0;
        end else if (tick) begin
            squash_reg <= live && is_snb && bit_clear;
        end
    end

    // Speed register; its divisor reaches the divider after this tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            speed_reg <= bsx_pkg::SPEED_RESET;
        end else if (live && is_speed) begin
            speed_reg <= immediate_byte;
        end
    end

    // Flags from a subtract.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            carry_reg <= 1'b0;
            dc_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else if (live && is_sub) begin
            carry_reg <= !diff[8];
            dc_reg <= !low_diff[4];
            zero_reg <= diff[7:0] == 8'h00;
        end
    end

    assign carry_flag = carry_reg;
    assign digit_carry_flag = dc_reg;
    assign zero_flag = zero_reg;
    assign clock_speed_control = speed_reg;
    assign power_down_select = speed_reg[bsx_pkg::PWRD_LSB +: 2];
    assign clock_source_select = speed_reg[bsx_pkg::CLKSRC_LSB +: 2];
    assign core_clock_divisor = speed_reg[DIV_W-1:0];

    // Clocks counted since the last instruction boundary; it feeds the cycle length check
    // and is kept apart from the divider so that a divider fault cannot hide itself.
    logic [DIV_W:0] span_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            span_reg <= '0;
        end else if (tick) begin
            span_reg <= '0;
        end else begin
            span_reg <= span_reg + 1'b1;
        end
    end

    // Bit operations: at most one bit may change, and the chosen bit must end up set.
    a_setb_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_setb |-> mem_we && mem_wdata[insn[bsx_pkg::BIT_LSB +: bsx_pkg::BIT_W]]
        && $countones(mem_wdata ^ memory_operand) <= 1)
        else $error("set-bit data wrong");

    // Skip and squash: a clear bit marks the next cycle, which then writes nothing.
    a_skip_marks: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_snb && bit_clear |=> skip_active)
        else $error("clear bit did not skip");
    a_skip_squash: assert property (@(posedge clock) disable iff (!rst_n)
        insn_fetch && skip_active |-> !mem_we && !acc_we)
        else $error("skipped instruction wrote");
    a_squash_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        insn_fetch && skip_active
        |=> $stable({clock_speed_control, carry_flag, digit_carry_flag, zero_flag}))
        else $error("skipped instruction changed state");
    a_skip_holds: assert property (@(posedge clock) disable iff (!rst_n)
        skip_active && !insn_fetch |=> skip_active)
        else $error("skip ended inside its cycle");
    a_no_skip_set: assert property (@(posedge clock) disable iff (!rst_n)
        tick && live && is_snb && !bit_clear |=> !squash_reg)
        else $error("skip without clear bit");

    // Speed register and instruction timing.
    a_speed_load: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_speed |=> speed_reg == $past(immediate_byte))
        else $error("speed not loaded");
    a_fields_map: assert property (@(posedge clock) disable iff (!rst_n)
        core_clock_divisor == clock_speed_control[3:0]
        && clock_source_select == clock_speed_control[5:4])
        else $error("speed field map wrong");
    a_cycle_len: assert property (@(posedge clock) disable iff (!rst_n)
        tick |-> span_reg == ((core_clock_divisor > 1) ? core_clock_divisor - 1 : 0))
        else $error("instruction cycle length wrong");

    // Subtract results and flags.
    a_sub_mem: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_sub_fr |-> mem_we && !acc_we
        && mem_wdata == 8'(memory_operand - acc_in))
        else $error("sub to memory wrong");
    a_sub_acc: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_sub_w |-> !mem_we && acc_wdata == 8'(memory_operand - acc_in))
        else $error("sub to accumulator wrong");
    a_carry_flag: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_sub |=> carry_flag == ($past(minuend) >= $past(acc_in)))
        else $error("carry wrong");
    a_dc_flag: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_sub |=> digit_carry_flag == ($past(minuend[3:0]) >= $past(acc_in[3:0])))
        else $error("digit carry wrong");
    a_zero_flag: assert property (@(posedge clock) disable iff (!rst_n)
        live && is_sub |=> zero_flag == ($past(minuend) == $past(acc_in)))
        else $error("zero wrong");

    // Scenarios worth seeing at least once.
    c_skip: cover property (@(posedge clock) live && is_snb && bit_clear);
    c_no_skip: cover property (@(posedge clock) live && is_snb && !bit_clear);
    c_speed: cover property (@(posedge clock) live && is_speed);
    c_borrow: cover property (@(posedge clock) live && is_sub && diff[8]);
    c_slow_cycle: cover property (@(posedge clock) tick && core_clock_divisor > 1);
endmodule

// >>> common/bsx_pkg.sv
// Package for the bit-set, skip, speed and subtract execute block.
// Assumes a 16-bit instruction word and a 9-bit data memory address.
package bsx_pkg;
    localparam int INSN_W = 16;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    // Opcode match values and masks.
    localparam logic [15:0] OP_SETB = 16'h9000;
    localparam logic [15:0] MASK_BIT = 16'hf000;
    localparam logic [15:0] OP_SNB = 16'ha000;
    localparam logic [15:0] OP_SPEED = 16'h0100;
    localparam logic [15:0] MASK_LIT = 16'hff00;
    localparam logic [15:0] OP_SUB_FR = 16'h0a00;
    localparam logic [15:0] OP_SUB_W = 16'h0800;
    localparam logic [15:0] MASK_FR = 16'hfe00;
    localparam logic [15:0] OP_SUB_LIT = 16'h7a00;
    // Field positions inside the instruction word.
    localparam int BIT_LSB = 9;
    localparam int BIT_W = 3;
    localparam int LIT_W = 8;
    // Clock speed control layout and reset value.
    localparam int PWRD_LSB = 6;
    localparam int CLKSRC_LSB = 4;
    localparam int DIV_W = 4;
    localparam logic [7:0] SPEED_RESET = 8'h00;
    // Timing.
    localparam int CLOCK_MHZ = 250;
    localparam int SKIP_CYCLES = 2;
endpackage

// >>> hdl/bsx_divider.sv
// Core clock enable divider.
// Assumes the divisor field is stable and changes only at an instruction boundary.
`timescale 1ns/1ns
module bsx_divider #(
    parameter int DIV_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);
    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] count_next;
    logic last;

    // A field value of zero or one runs the core every clock.
    assign last = (count_reg + 1'b1 >= divisor) || (divisor == '0);
    assign count_next = last ? '0 : count_reg + 1'b1;
    assign tick = last;

    // Counts clocks within one instruction cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// >>> bench/bsx_prog_mem.sv
// Program memory model that supplies instruction words to the execute block.
// Assumes the bench fills every rom word at time zero and that pc advances after each fetch.
`timescale 1ns/1ns
module bsx_prog_mem (
    input wire logic clock,
    input wire logic rstn,
    input wire logic insn_fetch,
    output logic [15:0] insn
);
    logic [15:0] rom [0:31];
    logic [4:0] pc;
    logic take;
    // A fetch seen at the rising edge moves the word on at the next falling edge.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) take <= 1'b0;
        else take <= insn_fetch;
    end
    always @(negedge clock or negedge rstn) begin
        if (!rstn) pc <= 5'h00;
        else if (take) pc <= pc + 5'h01;
    end
    assign insn = rom[pc];
endmodule

// >>> bench/bsx_exec_tb.sv
// Self-checking bench for the execute block with data memory and accumulator models.
// Assumes the program memory model above and checks after each run call, which runs one or two instructions.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t %h %h", $time, (a), (b)); end end
module bsx_exec_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] insn;
    logic insn_fetch, mem_we, acc_we, carry_flag, digit_carry_flag, zero_flag, skip_active;
    logic [8:0] mem_addr;
    logic [7:0] mem_wdata, acc_wdata, clock_speed_control;
    logic [7:0] acc = 8'h06;
    logic [1:0] power_down_select, clock_source_select;
    logic [3:0] core_clock_divisor;
    logic [7:0] dmem [0:511];
    int failures = 0;
    int tests_run = 0;
    int cyc;
    localparam logic [15:0] PROG [0:12] = '{16'h9610, 16'h0a11, 16'h0812, 16'h7a03, 16'h7a04,
        16'ha413, 16'h9014, 16'ha013, 16'h0a15, 16'h0134, 16'h9216, 16'h01c8, 16'h0000};
    // The clock toggles every 2 ns for a 250 MHz rate.
    initial begin
        forever #2 clock = ~clock;
    end
    // Data memory and accumulator take the block's write strobes.
    always @(posedge clock) begin
        if (mem_we) dmem[mem_addr] <= mem_wdata;
        if (acc_we) acc <= acc_wdata;
    end
    bsx_prog_mem bsx_prog_mem_inst (.clock(clock), .rstn(rstn), .insn_fetch(insn_fetch),
        .insn(insn));
    bsx_exec bsx_exec_inst (.clock(clock), .rstn(rstn), .insn(insn), .insn_fetch(insn_fetch),
        .mem_rdata(dmem[mem_addr]), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .acc_in(acc), .acc_wdata(acc_wdata), .acc_we(acc_we), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .clock_speed_control(clock_speed_control), .power_down_select(power_down_select),
        .clock_source_select(clock_source_select), .core_clock_divisor(core_clock_divisor),
        .skip_active(skip_active));
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Lets n instruction cycles pass, keeping the clock count of the last one in cyc.
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            cyc = 1;
            while (insn_fetch !== 1'b1 && cyc < 64) begin
                @(negedge clock);
                cyc++;
            end
            if (cyc >= 64) begin
                failures++;
                results();
            end
            @(negedge clock);
        end
    endtask
    // Runs the test program and checks memory, accumulator, flags and timing after each step.
    initial begin
        for (int i = 0; i < 512; i++) begin
            dmem[i] = 8'h00;
        end
        {dmem[16], dmem[17], dmem[18], dmem[19], dmem[21]} = 40'h4135050480;
        // Words past the program read as zero, which the block ignores.
        for (int i = 0; i < 32; i++) begin
            bsx_prog_mem_inst.rom[i] = (i < 13) ? PROG[i] : 16'h0000;
        end
        @(negedge clock);
        repeat (9) @(negedge clock);
        rstn = 1'b1;
        `CHK({clock_speed_control, carry_flag, digit_carry_flag, zero_flag}, 11'h000)
        run(1);
        `CHK(dmem[16], 8'h49)
        run(1);
        `CHK({dmem[17], acc, carry_flag, digit_carry_flag, zero_flag}, 19'h17834)
        run(1);
        `CHK({dmem[18], acc, carry_flag, digit_carry_flag, zero_flag}, 19'h02ff8)
        run(1);
        `CHK({acc, carry_flag, digit_carry_flag, zero_flag}, 11'h020)
        run(1);
        `CHK({acc, carry_flag, digit_carry_flag, zero_flag}, 11'h007)
        run(2);
        `CHK(dmem[20], 8'h01)
        run(1);
        `CHK(skip_active, 1'b1)
        run(1);
        `CHK({dmem[21], acc, carry_flag, digit_carry_flag, zero_flag, skip_active}, 20'h8000e)
        run(1);
        `CHK({power_down_select, clock_source_select, core_clock_divisor}, 8'h34)
        `CHK(cyc, 1)
        run(1);
        `CHK({dmem[22], 4'(cyc)}, 12'h024)
        run(1);
        `CHK({clock_speed_control, 4'(cyc)}, 12'hc84)
        run(1);
        `CHK(cyc, 8)
        results();
    end
endmodule
